/* File: mcc_pkg.sv */
`default_nettype none
package mcc_pkg;
    // Centre count, shadowed centre and shadow buffer shape
    localparam int unsigned MCC_NUM_CENTRES   = 15;
    localparam int unsigned MCC_MSG_W         = 64;
    localparam int unsigned MCC_SHADOW_DEPTH  = 1;
    localparam logic [3:0]  MCC_SHADOW_CENTRE = 4'hf;
    localparam logic [7:0]  MCC_CTRL_RESET    = 8'h00;
    localparam logic [7:0]  MCC_READ_IDLE     = 8'h00;

    // Special function addresses, centre 1 in entry 0
    localparam logic [7:0] MCC_M1C_OFFSET = 8'hab;
    localparam logic [7:0] MCC_M2C_OFFSET = 8'hac; // message_centre_two_control
    localparam logic [14:0][7:0] MCC_CENTRE_ADDR = {
        8'hbc, 8'hbb, 8'hba, 8'hb9, 8'hb8, 8'hb7, 8'hb6, 8'hb5,
        8'hb4, 8'hb3, 8'haf, 8'hae, 8'had, MCC_M2C_OFFSET, MCC_M1C_OFFSET};

    // Centre control register layout, bit 7 first
    typedef struct packed {
        logic centre_ready;
        logic transmit_irq_enable;
        logic receive_irq_enable;
        logic centre_irq_flag;
        logic remote_request_pending;
        logic host_transmit_request;
        logic rx_overwrite_tx_inhibit;
        logic data_updated;
    } mcc_ctrl_s;

    // Events reported by the protocol engine
    typedef enum logic [1:0] {
        MCC_EV_NONE,
        MCC_EV_RX,
        MCC_EV_TX,
        MCC_EV_REMOTE
    } mcc_ev_kind_e;

    typedef struct packed {
        mcc_ev_kind_e           kind;
        logic [3:0]             centre;
        logic [MCC_MSG_W-1:0]   data;
    } mcc_event_s;

    typedef struct packed {
        logic                   valid;
        logic [MCC_MSG_W-1:0]   data;
    } mcc_load_s;

    typedef enum logic [1:0] {
        MCC_SH_EMPTY,
        MCC_SH_FULL,
        MCC_SH_MOVE
    } mcc_sh_state_e;
endpackage : mcc_pkg
`default_nettype wire

/* File: mcc_shadow_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module mcc_shadow_mem #(
    parameter int unsigned WIDTH = 64,
    parameter int unsigned DEPTH = 1,
    parameter int unsigned AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_shape
        $error("mcc_shadow_mem needs DEPTH and WIDTH of at least 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_data_reg;

    // Storage array, no reset needed
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_reg <= '0;
        end else if (rd_en) begin
            rd_data_reg <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_reg;
endmodule : mcc_shadow_mem
`default_nettype wire

/* File: mcc_centre.sv */
`timescale 1ns/1ps
`default_nettype none
module mcc_centre #(
    parameter bit SHADOWED = 1'b0
) (
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    input  wire logic               soft_rst,
    input  wire logic               dir_tx,
    input  wire logic               overwrite_enable,
    input  wire logic               sw_wr,
    input  wire mcc_pkg::mcc_ctrl_s sw_wdata,
    input  wire logic               rx_store,
    input  wire logic               tx_done,
    input  wire logic               remote_req,
    input  wire logic               shadow_ovf,
    input  wire logic               shadow_moved,
    output mcc_pkg::mcc_ctrl_s      ctrl,
    output logic                    tx_want,
    output logic                    rx_accept
);
    mcc_pkg::mcc_ctrl_s ctrl_reg;
    mcc_pkg::mcc_ctrl_s ctrl_next;

    // Hardware clears, then software, then hardware sets so a set wins [R23]
    always_comb begin
        ctrl_next = ctrl_reg;
        if (tx_done) begin
            ctrl_next.host_transmit_request = 1'b0; // [R1] [R20]
            if (dir_tx) begin
                ctrl_next.remote_request_pending = 1'b0;
            end
        end
        if (sw_wr) begin
            ctrl_next.centre_ready        = sw_wdata.centre_ready;
            ctrl_next.transmit_irq_enable = sw_wdata.transmit_irq_enable;
            ctrl_next.receive_irq_enable  = sw_wdata.receive_irq_enable;
            ctrl_next.centre_irq_flag     = sw_wdata.centre_irq_flag;
            ctrl_next.remote_request_pending = ctrl_next.remote_request_pending
                & sw_wdata.remote_request_pending;
            // A stale 1 cannot undo a completion in the same cycle
            ctrl_next.host_transmit_request = sw_wdata.host_transmit_request
                & (ctrl_next.host_transmit_request | !ctrl_reg.host_transmit_request); // [R2]
            ctrl_next.data_updated = sw_wdata.data_updated; // [R14]
            if (dir_tx) begin
                ctrl_next.rx_overwrite_tx_inhibit = sw_wdata.rx_overwrite_tx_inhibit; // [R13]
            end else if (!SHADOWED && !sw_wdata.data_updated) begin
                ctrl_next.rx_overwrite_tx_inhibit = 1'b0; // [R7]
            end
        end
        if (rx_store) begin
            if (!SHADOWED && ctrl_reg.data_updated) begin
                ctrl_next.rx_overwrite_tx_inhibit = 1'b1; // [R5] [R4]
            end
            ctrl_next.data_updated = 1'b1; // [R15]
            if (ctrl_reg.receive_irq_enable) begin
                ctrl_next.centre_irq_flag = 1'b1; // [R8]
            end
        end
        if (tx_done && ctrl_reg.transmit_irq_enable && !SHADOWED) begin
            ctrl_next.centre_irq_flag = 1'b1;
        end
        if (remote_req) begin
            ctrl_next.remote_request_pending = 1'b1; // [R12]
            if (dir_tx && !SHADOWED) begin
                ctrl_next.host_transmit_request = 1'b1; // [R3]
            end
        end
        if (shadow_moved) begin
            ctrl_next.rx_overwrite_tx_inhibit = 1'b0; // [R9]
        end
        if (shadow_ovf) begin
            ctrl_next.rx_overwrite_tx_inhibit = 1'b1; // [R9]
        end
    end

    // Control flops, cleared by either reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= mcc_pkg::mcc_ctrl_s'(mcc_pkg::MCC_CTRL_RESET);
        end else if (soft_rst) begin
            ctrl_reg <= mcc_pkg::mcc_ctrl_s'(mcc_pkg::MCC_CTRL_RESET); // [R14]
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Requests toward the protocol engine
    assign ctrl      = ctrl_reg;
    assign tx_want   = !SHADOWED && ctrl_reg.centre_ready && ctrl_reg.host_transmit_request
                       && (!dir_tx || !ctrl_reg.rx_overwrite_tx_inhibit); // [R11] [R18] [R22]
    assign rx_accept = ctrl_reg.centre_ready && !dir_tx
                       && (overwrite_enable || !ctrl_reg.data_updated); // [R6] [R22]
endmodule : mcc_centre
`default_nettype wire

/* File: mcc_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Receive centre: request sends remote frame, then clears
// R2: Transmit centre: request sends the stored data frame
// R3: Remote request also sets host request, same cycle
// R4: Bit 1 is overwrite flag or transmit inhibit
// R5: Store while data updated sets overwrite flag
// R6: Overwrite disabled and data updated: centre ignored
// R7: Clearing data updated clears overwrite flag
// R8: Stored message with receive irq enable sets flag
// R9: Centre 15 flag reports shadow overwrite, clears on move
// R10: Shadow moves once data updated and pending clear
// R11: Inhibit blocks transmit; centre 15 ignores inhibit
// R12: Remote request under inhibit waits as pending
// R13: Inhibit writable only in transmit direction
// R14: Data updated cleared only by software or reset
// R15: Successful receive sets data updated
// R16: Software clears data updated before read, rechecks
// R17: Without overwrite, software clears after reading
// R18: Remote frame gated only by ready and request
// R19: Software inhibits and clears before updating centre
// R20: Successful transmit clears host request
// R21: Centre two register at ACh, same layout
// R22: Centre not ready is ignored entirely; a pending shadow move still loads centre 15 when not ready
// R23: Hardware set beats simultaneous software clear
module mcc_control #(
    parameter int unsigned MSG_W        = mcc_pkg::MCC_MSG_W,
    parameter int unsigned SHADOW_DEPTH = mcc_pkg::MCC_SHADOW_DEPTH
) (
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire logic                controller_soft_reset,
    input  wire logic                overwrite_enable,
    input  wire logic [14:0]         dir_tx,
    input  wire logic [7:0]          sfr_addr,
    input  wire logic                sfr_wr,
    input  wire logic [7:0]          sfr_wdata,
    input  wire logic                sfr_rd,
    output logic      [7:0]          sfr_rdata,
    input  wire mcc_pkg::mcc_event_s engine_event,
    output logic      [14:0]         tx_want,
    output logic      [14:0]         rx_accept,
    output logic      [14:0]         irq_flags,
    output mcc_pkg::mcc_load_s       shadow_load
);
    localparam int unsigned SH_AW = (SHADOW_DEPTH > 1) ? $clog2(SHADOW_DEPTH) : 1;
    localparam int unsigned LAST  = mcc_pkg::MCC_NUM_CENTRES - 1;

    if (MSG_W != mcc_pkg::MCC_MSG_W || SHADOW_DEPTH < 1) begin : g_bad_param
        $error("mcc_control: MSG_W must match the event payload, depth at least 1");
    end

    mcc_pkg::mcc_ctrl_s [14:0] ctrl_q;
    mcc_pkg::mcc_sh_state_e    sh_state_reg;
    mcc_pkg::mcc_sh_state_e    sh_state_next;
    logic [7:0]                rdata_reg;
    logic [7:0]                rd_mux;
    logic [14:0]               addr_hit;
    logic [14:0]               ev_hit;
    logic [14:0]               rx_go;
    logic [14:0]               tx_go;
    logic [14:0]               rm_go;
    logic [MSG_W-1:0]          sh_rdata;

    // Event decode; centre numbers run 1 to 15
    wire        ev_valid = engine_event.kind != mcc_pkg::MCC_EV_NONE
                           && engine_event.centre != 4'h0;
    wire [3:0]  ev_idx   = engine_event.centre - 4'h1;
    wire        ev_rx    = engine_event.kind == mcc_pkg::MCC_EV_RX;
    wire        ev_tx    = engine_event.kind == mcc_pkg::MCC_EV_TX;
    wire        ev_rm    = engine_event.kind == mcc_pkg::MCC_EV_REMOTE;

    // Shadow buffer steering for the receive-only centre
    wire sh_empty  = sh_state_reg == mcc_pkg::MCC_SH_EMPTY;
    wire sh_full   = sh_state_reg == mcc_pkg::MCC_SH_FULL;
    wire sh_moving = sh_state_reg == mcc_pkg::MCC_SH_MOVE;
    wire rx15_ev   = ev_hit[LAST] && ev_rx && ctrl_q[LAST].centre_ready; // [R22]
    wire busy15    = ctrl_q[LAST].data_updated || ctrl_q[LAST].remote_request_pending
                     || !sh_empty;
    wire direct15  = rx15_ev && !busy15;
    wire sh_wr     = rx15_ev && busy15 && (!sh_full || overwrite_enable); // [R6]
    wire sh_ovf    = sh_wr && sh_full; // [R9]
    wire move_go   = sh_full && !sh_wr && !ctrl_q[LAST].data_updated
                     && !ctrl_q[LAST].remote_request_pending; // [R10]

    // One centre per generate step, each on its own address
    for (genvar i = 0; i < 15; i++) begin : g_centre
        localparam bit SH = (i == LAST);

        assign addr_hit[i] = sfr_addr == mcc_pkg::MCC_CENTRE_ADDR[i]; // [R21]
        assign ev_hit[i]   = ev_valid && ev_idx == 4'(i);
        assign tx_go[i]    = ev_hit[i] && ev_tx && ctrl_q[i].centre_ready; // [R22]
        assign rm_go[i]    = ev_hit[i] && ev_rm && ctrl_q[i].centre_ready; // [R22]
        if (SH) begin : g_sh
            assign rx_go[i] = direct15 || sh_moving;
        end else begin : g_norm
            assign rx_go[i] = ev_hit[i] && ev_rx && rx_accept[i]; // [R6]
        end

        mcc_centre #(
            .SHADOWED (SH)
        ) u_centre (
            .clk_sys          (clk_sys),
            .arst_n           (arst_n),
            .soft_rst         (controller_soft_reset),
            .dir_tx           (SH ? 1'b0 : dir_tx[i]),
            .overwrite_enable (overwrite_enable),
            .sw_wr            (sfr_wr && addr_hit[i]),
            .sw_wdata         (mcc_pkg::mcc_ctrl_s'(sfr_wdata)),
            .rx_store         (rx_go[i]),
            .tx_done          (tx_go[i]),
            .remote_req       (rm_go[i]),
            .shadow_ovf       (SH ? sh_ovf : 1'b0),
            .shadow_moved     (SH ? sh_moving : 1'b0),
            .ctrl             (ctrl_q[i]),
            .tx_want          (tx_want[i]),
            .rx_accept        (rx_accept[i])
        );

        assign irq_flags[i] = ctrl_q[i].centre_irq_flag;
    end

    // Shadow buffer state: fill, wait for the centre, move
    always_comb begin
        sh_state_next = sh_state_reg;
        case (sh_state_reg)
            mcc_pkg::MCC_SH_EMPTY: begin
                if (sh_wr) begin
                    sh_state_next = mcc_pkg::MCC_SH_FULL;
                end
            end
            mcc_pkg::MCC_SH_FULL: begin
                if (move_go) begin
                    sh_state_next = mcc_pkg::MCC_SH_MOVE; // [R10]
                end
            end
            mcc_pkg::MCC_SH_MOVE: begin
                sh_state_next = sh_wr ? mcc_pkg::MCC_SH_FULL : mcc_pkg::MCC_SH_EMPTY;
            end
            default: begin
                sh_state_next = mcc_pkg::MCC_SH_EMPTY;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sh_state_reg <= mcc_pkg::MCC_SH_EMPTY;
        end else if (controller_soft_reset) begin
            sh_state_reg <= mcc_pkg::MCC_SH_EMPTY;
        end else begin
            sh_state_reg <= sh_state_next;
        end
    end

    // Shadow message store, read out on the move
    mcc_shadow_mem #(
        .WIDTH (MSG_W),
        .DEPTH (SHADOW_DEPTH),
        .AW    (SH_AW)
    ) u_shadow (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .wr_en   (sh_wr),
        .wr_addr ('0),
        .wr_data (engine_event.data),
        .rd_en   (move_go),
        .rd_addr ('0),
        .rd_data (sh_rdata)
    );

    assign shadow_load.valid = sh_moving; // [R10]
    assign shadow_load.data  = sh_rdata;

    // Read selection over the centre addresses
    always_comb begin
        rd_mux = mcc_pkg::MCC_READ_IDLE;
        for (int k = 0; k < 15; k++) begin
            if (addr_hit[k]) begin
                rd_mux = ctrl_q[k];
            end
        end
    end

    // Read data held until the next read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= mcc_pkg::MCC_READ_IDLE;
        end else if (sfr_rd) begin
            rdata_reg <= rd_mux;
        end
    end

    assign sfr_rdata = rdata_reg;

    // Checks on centre behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n || controller_soft_reset);

    wire sw_to_ev = sfr_wr && ev_valid && addr_hit[ev_idx];

    a_remote_sets_req: assert property ( // [R3]
        ev_valid && ev_rm && ev_idx < 4'(LAST) && dir_tx[ev_idx]
        && ctrl_q[ev_idx].centre_ready && !sw_to_ev
        |=> ctrl_q[$past(ev_idx)].host_transmit_request
            && ctrl_q[$past(ev_idx)].remote_request_pending)
        else $error("remote request did not raise both request bits");

    a_tx_clears_req: assert property ( // [R20]
        ev_valid && ev_tx && ctrl_q[ev_idx].centre_ready && !sw_to_ev
        |=> !ctrl_q[$past(ev_idx)].host_transmit_request)
        else $error("host request not cleared after transmit");

    a_rx_sets_du: assert property ( // [R15]
        ev_valid && ev_rx && ev_idx < 4'(LAST) && rx_accept[ev_idx]
        |=> ctrl_q[$past(ev_idx)].data_updated)
        else $error("data updated not set after receive");

    a_rx_overwrite: assert property ( // [R5]
        ev_valid && ev_rx && ev_idx < 4'(LAST) && rx_accept[ev_idx]
        && ctrl_q[ev_idx].data_updated
        |=> ctrl_q[$past(ev_idx)].rx_overwrite_tx_inhibit)
        else $error("overwrite flag missing after store over data");

    a_rx_ignored: assert property ( // [R6]
        ev_valid && ev_rx && ev_idx < 4'(LAST) && !overwrite_enable
        && ctrl_q[ev_idx].data_updated && !sw_to_ev
        |=> ctrl_q[$past(ev_idx)] == $past(ctrl_q[ev_idx]))
        else $error("busy centre changed with overwrite disabled");

    a_du_clear_row: assert property ( // [R7]
        sfr_wr && addr_hit[0] && !sfr_wdata[0] && !dir_tx[0] && !rx_go[0]
        |=> !ctrl_q[0].rx_overwrite_tx_inhibit)
        else $error("overwrite flag survived data updated clear");

    a_rx_irq: assert property ( // [R8]
        rx_go[0] && ctrl_q[0].receive_irq_enable |=> irq_flags[0])
        else $error("receive did not raise centre flag");

    a_inhibit_blocks: assert property ( // [R11]
        dir_tx[2] && ctrl_q[2].rx_overwrite_tx_inhibit |-> !tx_want[2] && !tx_want[LAST])
        else $error("transmit wanted while inhibited");

    a_inhibit_release: assert property ( // [R12]
        ctrl_q[2].centre_ready && dir_tx[2] && ctrl_q[2].host_transmit_request
        && $fell(ctrl_q[2].rx_overwrite_tx_inhibit) |-> tx_want[2])
        else $error("pending request not released with inhibit");

    a_du_holds_tx: assert property ( // [R14]
        tx_go[2] && !(sfr_wr && addr_hit[2]) |=> $stable(ctrl_q[2].data_updated))
        else $error("data updated changed by transmission");

    a_ready_gates: assert property ( // [R22]
        !ctrl_q[2].centre_ready |-> !tx_want[2] && !rx_accept[2])
        else $error("idle centre offered to engine");

    a_shadow_move: assert property ( // [R10]
        move_go |=> shadow_load.valid ##1 ctrl_q[LAST].data_updated)
        else $error("shadow buffer not moved into centre");

    a_shadow_row: assert property ( // [R9]
        sh_ovf && !sh_moving |=> ctrl_q[LAST].rx_overwrite_tx_inhibit)
        else $error("shadow overwrite not flagged");

    a_rx_req_gate: assert property ( // [R18]
        ctrl_q[1].centre_ready && ctrl_q[1].host_transmit_request && !dir_tx[1]
        |-> tx_want[1])
        else $error("remote frame request blocked in receive");

    a_set_wins: assert property ( // [R23]
        rx_go[0] && sfr_wr && addr_hit[0] && !sfr_wdata[0] |=> ctrl_q[0].data_updated)
        else $error("software clear beat hardware set");

    a_rx_row_clean: assert property ( // [R5]
        rx_go[0] && !ctrl_q[0].data_updated && !ctrl_q[0].rx_overwrite_tx_inhibit
        |=> !ctrl_q[0].rx_overwrite_tx_inhibit)
        else $error("overwrite flag set by store into empty centre");

    a_inhibit_locked: assert property ( // [R13]
        sfr_wr && addr_hit[3] && !dir_tx[3] && sfr_wdata[1] && !rx_go[3]
        && !ctrl_q[3].rx_overwrite_tx_inhibit |=> !ctrl_q[3].rx_overwrite_tx_inhibit)
        else $error("inhibit written in receive direction");

    a_du_sw_only: assert property ( // [R14]
        ctrl_q[0].data_updated && !(sfr_wr && addr_hit[0]) |=> ctrl_q[0].data_updated)
        else $error("data updated cleared without software write");

    a_shadow_clear: assert property ( // [R9]
        shadow_load.valid |=> !ctrl_q[LAST].rx_overwrite_tx_inhibit)
        else $error("shadow overwrite flag kept after move");

    a_read_data: assert property ( // [R21]
        sfr_rd && addr_hit[1] |=> sfr_rdata == $past(ctrl_q[1]))
        else $error("centre two register read back wrong");

    a_idle_deaf: assert property ( // [R22]
        ev_valid && ev_rx && ev_idx < 4'(LAST) && !ctrl_q[ev_idx].centre_ready && !sw_to_ev
        |=> ctrl_q[$past(ev_idx)] == $past(ctrl_q[ev_idx]))
        else $error("idle centre changed by receive");
endmodule : mcc_control
`default_nettype wire

/* File: mcc_remote_node.sv */
`timescale 1ns/1ps
`default_nettype none
module mcc_remote_node (
    input  wire logic                clk_sys,
    input  wire logic [14:0]         tx_want,
    input  wire logic                auto_en,
    input  wire logic [3:0]          delay,
    input  wire logic                cmd_go,
    input  wire mcc_pkg::mcc_event_s cmd,
    output mcc_pkg::mcc_event_s      engine_event
);
    mcc_pkg::mcc_event_s auto_ev;
    mcc_pkg::mcc_event_s nxt_ev;
    logic [3:0]          cnt;

    // Commanded frames pass straight through, else the bus winner
    assign engine_event = cmd_go ? cmd : auto_ev;

    // Idle until the first wanted frame
    initial begin
        auto_ev = '0;
        cnt     = 4'h0;
    end

    // Lowest wanted centre wins the bus after delay cycles
    always @(negedge clk_sys) begin
        nxt_ev = '0;
        if (auto_en && |tx_want) begin
            if (cnt == delay) begin
                for (int i = 14; i >= 0; i--) begin
                    if (tx_want[i]) nxt_ev.centre = 4'(i + 1);
                end
                nxt_ev.kind = mcc_pkg::MCC_EV_TX;
                cnt          = 4'h0;
            end else begin
                cnt = cnt + 4'h1; // Slow answer
            end
        end else begin
            cnt = 4'h0;
        end
        auto_ev = nxt_ev; // One update per edge
    end
endmodule : mcc_remote_node
`default_nettype wire

/* File: mcc_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mcc_control_bench;
    logic                clk_sys;
    logic                arst_n;
    logic                controller_soft_reset;
    logic                overwrite_enable;
    logic [14:0]         dir_tx;
    logic [7:0]          sfr_addr;
    logic                sfr_wr;
    logic [7:0]          sfr_wdata;
    logic                sfr_rd;
    logic [7:0]          sfr_rdata;
    logic [14:0]         tx_want;
    logic [14:0]         rx_accept;
    logic [14:0]         irq_flags;
    logic                auto_en;
    logic [3:0]          delay;
    logic                cmd_go;
    mcc_pkg::mcc_event_s cmd;
    mcc_pkg::mcc_event_s engine_event;
    mcc_pkg::mcc_load_s  shadow_load;
    int                  errors;
    int                  checks;
    int                  n;

    mcc_control i_mcc_control (
        .clk_sys(clk_sys), .arst_n(arst_n), .controller_soft_reset(controller_soft_reset),
        .overwrite_enable(overwrite_enable), .dir_tx(dir_tx), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .engine_event(engine_event), .tx_want(tx_want), .rx_accept(rx_accept),
        .irq_flags(irq_flags), .shadow_load(shadow_load));

    mcc_remote_node i_mcc_remote_node (
        .clk_sys(clk_sys), .tx_want(tx_want), .auto_en(auto_en), .delay(delay),
        .cmd_go(cmd_go), .cmd(cmd), .engine_event(engine_event));

    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Byte and message comparisons
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk64

    // Register bus cycles, driven at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        @(negedge clk_sys);
        chk8("sfr_rdata", exp, sfr_rdata);
    endtask : rd

    // One event from the far side
    task automatic ev(input mcc_pkg::mcc_ev_kind_e k, input logic [3:0] c, input logic [63:0] d);
        @(negedge clk_sys);
        cmd.kind   = k;
        cmd.centre = c;
        cmd.data   = d;
        cmd_go     = 1'b1;
        @(negedge clk_sys);
        cmd_go = 1'b0;
    endtask : ev

    // Counts and verdict, the one place the run ends
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // An exhausted wait counts as a mismatch
    task automatic give_up(input int k);
        if (k >= 20) begin
            errors++;
            $display("Error wait expected done seen timeout");
            give_verdict();
        end
    endtask : give_up

    // Main sequence
    initial begin
        arst_n = 1'b0; controller_soft_reset = 1'b0; overwrite_enable = 1'b0;
        dir_tx = 15'h0004; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_wdata = 8'h00;
        sfr_rd = 1'b0; auto_en = 1'b1; delay = 4'h3; cmd_go = 1'b0; cmd = '0;
        errors = 0; checks = 0;
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        for (n = 0; n < 15; n++) rd(mcc_pkg::MCC_CENTRE_ADDR[n], 8'h00);
        rd(8'hb0, 8'h00);
        // Receive centre sends its remote frame, slow bus
        wr(8'hac, 8'h84);
        chk8("tx_want", 8'h01, {7'h0, tx_want[1]});
        for (n = 0; n < 20 && tx_want[1] !== 1'b0; n++) @(negedge clk_sys);
        give_up(n);
        rd(8'hac, 8'h80);
        // Stores, overwrite flag and its clearing
        wr(8'hab, 8'ha0);
        ev(mcc_pkg::MCC_EV_RX, 4'h1, 64'h0);
        rd(8'hab, 8'hb1);
        overwrite_enable = 1'b1;
        ev(mcc_pkg::MCC_EV_RX, 4'h1, 64'h0);
        rd(8'hab, 8'hb3);
        wr(8'hab, 8'ha0);
        rd(8'hab, 8'ha0);
        overwrite_enable = 1'b0;
        ev(mcc_pkg::MCC_EV_RX, 4'h1, 64'h0);
        ev(mcc_pkg::MCC_EV_RX, 4'h1, 64'h0);
        rd(8'hab, 8'hb1);
        chk8("rx_accept", 8'h00, {7'h0, rx_accept[0]});
        wr(8'hab, 8'ha0);
        // Store and software clear in the same cycle
        @(negedge clk_sys);
        cmd.kind = mcc_pkg::MCC_EV_RX;
        cmd.centre = 4'h1;
        cmd_go = 1'b1;
        sfr_addr = 8'hab;
        sfr_wdata = 8'ha0;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        cmd_go = 1'b0;
        sfr_wr = 1'b0;
        rd(8'hab, 8'hb1);
        // Transmit centre under inhibit, prompt bus
        delay = 4'h0;
        wr(8'had, 8'h82);
        ev(mcc_pkg::MCC_EV_REMOTE, 4'h3, 64'h0);
        rd(8'had, 8'h8e);
        chk8("tx_want", 8'h00, {7'h0, tx_want[2]});
        wr(8'had, 8'h8d);
        for (n = 0; n < 20 && tx_want[2] !== 1'b0; n++) @(negedge clk_sys);
        give_up(n);
        rd(8'had, 8'h81);
        // Inhibit write refused in receive, idle centre deaf
        wr(8'hae, 8'h82);
        rd(8'hae, 8'h80);
        ev(mcc_pkg::MCC_EV_RX, 4'h5, 64'h0);
        rd(8'haf, 8'h00);
        // Centre 15 shadow overflow and move
        overwrite_enable = 1'b1;
        wr(8'hbc, 8'h80);
        ev(mcc_pkg::MCC_EV_RX, 4'hf, 64'ha1);
        rd(8'hbc, 8'h81);
        ev(mcc_pkg::MCC_EV_RX, 4'hf, 64'hb2);
        ev(mcc_pkg::MCC_EV_RX, 4'hf, 64'hc3);
        rd(8'hbc, 8'h83);
        wr(8'hbc, 8'h80);
        for (n = 0; n < 20 && shadow_load.valid !== 1'b1; n++) @(negedge clk_sys);
        give_up(n);
        chk64("shadow_load", 64'hc3, shadow_load.data);
        rd(8'hbc, 8'h81);
        // Soft reset clears the centre registers, checked by reading centre 1 back as 00
        @(negedge clk_sys);
        controller_soft_reset = 1'b1;
        @(negedge clk_sys);
        controller_soft_reset = 1'b0;
        rd(8'hab, 8'h00);
        give_verdict();
    end
endmodule : mcc_control_bench
`default_nettype wire
